// ==== gpio_port.sv ====
// APB register file and pin array of the general purpose I/O block
`include "gpio_map.svh"
module gpio_port import gpio_pkg::*; (
   // Clock and reset
   input  wire logic                    i_mclk,
   input  wire logic                    i_rst_n,
   // APB slave
   input  wire logic                    i_psel,
   input  wire logic                    i_penable,
   input  wire logic                    i_pwrite,
   input  wire logic [11:0]             i_paddr,
   input  wire logic [31:0]             i_pwdata,
   output logic      [31:0]             o_prdata,
   output logic                         o_pready,
   output logic                         o_pslverr,
   // Alternate functions
   input  wire logic [`PIN_COUNT-1:0]   i_alt_out,
   input  wire logic [`PIN_COUNT-1:0]   i_alt_oe,
   output logic      [`PIN_COUNT-1:0]   o_alt_in,
   // Pins
   input  wire logic [`PIN_COUNT-1:0]   i_pin,
   output logic      [`PIN_COUNT-1:0]   o_pin_out,
   output logic      [`PIN_COUNT-1:0]   o_pin_oe
);
   cfg_type                 cfg_q      [`PIN_COUNT];
   cfg_type                 next_cfg   [`PIN_COUNT];
   logic [`PIN_COUNT-1:0]   data_q;
   logic [`PIN_COUNT-1:0]   next_data;
   logic [`PIN_COUNT-1:0]   rd_bits;
   logic [`PIN_COUNT-1:0]   writable;
   logic [31:0]             next_prdata;
   logic                    next_pready;
   logic                    next_pslverr;
   logic [9:0]              idx;
   logic [9:0]              cfg_off;
   reg_sel_type             sel;
   logic                    setup;
   logic                    wr_en;

   // ****************************************
   // Per-pin cells
   // ****************************************
   for (genvar p = 0; p < `PIN_COUNT; p++) begin : g_pin
      localparam logic [`PIN_COUNT-1:0] EDGE_M = `EDGE_CAP_MASK;
      localparam logic [`PIN_COUNT-1:0] EXEM_M = `POL_EXEMPT_MASK;
      gpio_pin_cell #(
         .EDGE_CAP   (EDGE_M[p]),
         .POL_EXEMPT (EXEM_M[p])
      ) u_cell (
         .i_mclk     (i_mclk),
         .i_rst_n    (i_rst_n),
         .i_cfg      (cfg_q[p]),
         .i_data     (data_q[p]),
         .o_rd_bit   (rd_bits[p]),
         .i_alt_out  (i_alt_out[p]),
         .i_alt_oe   (i_alt_oe[p]),
         .o_alt_in   (o_alt_in[p]),
         .i_pin      (i_pin[p]),
         .o_pin_out  (o_pin_out[p]),
         .o_pin_oe   (o_pin_oe[p])
      );
      // Edge mode makes the pin an input regardless of bit 0
      assign writable[p] = ~cfg_q[p][`CFG_DIR_BIT] &
                           ~(EDGE_M[p] & cfg_q[p][`CFG_EDGE_BIT]);
   end

   // ****************************************
   // Address decode
   // ****************************************
   always_comb begin
      idx     = i_paddr[11:2];
      cfg_off = idx - `IDX_CFG_BASE;
      sel     = SEL_NONE;
      if (i_paddr[1:0] == 2'b00) begin
         if (idx == `IDX_PLAIN_DATA) begin
            sel = SEL_PLAIN;
         end else if (idx == `IDX_LED_DATA) begin
            sel = SEL_LED;
         end else if (idx == `IDX_EXP_DATA) begin
            sel = SEL_EXP;
         end else if (idx >= `IDX_CFG_BASE && cfg_off < 10'(`PIN_COUNT)) begin
            sel = SEL_CFG;
         end
      end
      setup = i_psel & ~i_penable;
      // Single wait-free access: pready rises in the access cycle
      wr_en = i_psel & i_penable & o_pready & i_pwrite;
   end

   // ****************************************
   // Register state
   // ****************************************
   always_comb begin
      next_data    = data_q;
      next_prdata  = o_prdata;
      next_pready  = setup;
      next_pslverr = setup & (sel == SEL_NONE);
      for (int k = 0; k < `PIN_COUNT; k++) begin
         next_cfg[k] = cfg_q[k];
         if (wr_en && sel == SEL_CFG && cfg_off == 10'(k)) begin
            next_cfg[k] = i_pwdata[7:0];
         end
         // Bank writes touch only output pins; bits with no pin have no storage
         if (wr_en && writable[k]) begin
            if (sel == SEL_PLAIN && k < `LED_FIRST_PIN) begin
               next_data[k] = i_pwdata[k - `PLAIN_FIRST_PIN];
            end else if (sel == SEL_LED && k >= `LED_FIRST_PIN && k < `EXP_FIRST_PIN) begin
               next_data[k] = i_pwdata[k - `LED_FIRST_PIN];
            end else if (sel == SEL_EXP && k >= `EXP_FIRST_PIN) begin
               next_data[k] = i_pwdata[k - `EXP_FIRST_PIN];
            end
         end
      end
      if (setup && !i_pwrite) begin
         unique case (sel)
            SEL_PLAIN: next_prdata = {24'h000000, rd_bits[`LED_FIRST_PIN-1:0]};
            SEL_LED:   next_prdata = {29'h00000000,
                                      rd_bits[`EXP_FIRST_PIN-1:`LED_FIRST_PIN]};
            SEL_EXP:   next_prdata = {24'h000000, rd_bits[`PIN_COUNT-1:`EXP_FIRST_PIN]};
            SEL_CFG:   next_prdata = {24'h000000, cfg_q[cfg_off[4:0]]};
            SEL_NONE:  next_prdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         data_q    <= `DATA_RESET;
         o_prdata  <= 32'h00000000;
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         for (int k = 0; k < `PIN_COUNT; k++) begin
            cfg_q[k] <= `CFG_RESET;
         end
      end else begin
         data_q    <= next_data;
         o_prdata  <= next_prdata;
         o_pready  <= next_pready;
         o_pslverr <= next_pslverr;
         for (int k = 0; k < `PIN_COUNT; k++) begin
            cfg_q[k] <= next_cfg[k];
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   a_pready_after_setup: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      setup |=> o_pready ##1 !o_pready)
      else $error("pready not one cycle after setup");
   a_unmapped_error: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (setup && sel == SEL_NONE) |=> (o_pslverr && o_pready))
      else $error("unmapped access not flagged");
   a_cfg_write_lands: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (wr_en && sel == SEL_CFG && cfg_off == 10'h000) |=> cfg_q[0] == $past(i_pwdata[7:0]))
      else $error("configuration write lost");
   a_input_write_ignored: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (wr_en && sel == SEL_PLAIN && cfg_q[0][`CFG_DIR_BIT]) |=> $stable(data_q[0]))
      else $error("write changed input pin data");
   a_output_write_stores: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (wr_en && sel == SEL_EXP && writable[`EXP_FIRST_PIN])
      |=> data_q[`EXP_FIRST_PIN] == $past(i_pwdata[0]))
      else $error("output write not stored");
   a_reserved_read_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (setup && !i_pwrite && sel == SEL_LED) |=> o_prdata[31:3] == 29'h00000000)
      else $error("reserved data bits not zero");
   a_pslverr_with_ready: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      o_pslverr |-> o_pready)
      else $error("slave error outside access cycle");
   a_mapped_no_error: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (setup && sel != SEL_NONE) |=> !o_pslverr)
      else $error("mapped access flagged as error");
   a_misaligned_error: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (setup && i_paddr[1:0] != 2'b00) |=> o_pslverr)
      else $error("misaligned access not flagged");
   a_unmapped_write_ignored: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (wr_en && sel == SEL_NONE) |=> $stable(data_q))
      else $error("unmapped write changed data");
   a_data_write_only: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      !wr_en |=> $stable(data_q))
      else $error("data changed without a write");
   a_cfg_write_only: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      !wr_en |=> $stable(cfg_q[0]))
      else $error("configuration changed without a write");
   a_cfg_read_value: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (setup && !i_pwrite && sel == SEL_CFG && cfg_off == 10'h000)
      |=> o_prdata == {24'h000000, $past(cfg_q[0])})
      else $error("configuration read value wrong");
   a_led_write_stores: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (wr_en && sel == SEL_LED && writable[`LED_FIRST_PIN])
      |=> data_q[`LED_FIRST_PIN] == $past(i_pwdata[0]))
      else $error("led bank write not stored");
   a_prdata_upper_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      o_pready |-> o_prdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");

   // ****************************************
   // Coverage
   // ****************************************
   c_back_to_back: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
      o_pready ##1 setup);
   c_data_write: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
      wr_en && sel == SEL_PLAIN);
   c_cfg_read: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
      setup && !i_pwrite && sel == SEL_CFG);
   c_unmapped: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
      setup && sel == SEL_NONE);
endmodule

// ==== gpio_map.svh ====
// Register offsets, field positions, reset values and pin layout of the GPIO block
`ifndef GPIO_MAP_SVH
`define GPIO_MAP_SVH

// ****************************************
// Pin layout
// ****************************************
`define PIN_COUNT        19
`define PLAIN_FIRST_PIN  0
`define LED_FIRST_PIN    8
`define EXP_FIRST_PIN    11
`define LED_PIN_COUNT    3
`define EDGE_CAP_MASK    19'h00300
`define POL_EXEMPT_MASK  19'h00400

// ****************************************
// Register indices (byte address is four times the index)
// ****************************************
`define IDX_PLAIN_DATA   10'h04a
`define IDX_LED_DATA     10'h050
`define IDX_EXP_DATA     10'h051
`define IDX_CFG_BASE     10'h060

// ****************************************
// Configuration fields and reset values
// ****************************************
`define CFG_DIR_BIT      0
`define CFG_POL_BIT      1
`define CFG_ALT_BIT      2
`define CFG_EDGE_BIT     3
`define CFG_DRV_BIT      7
`define CFG_RESET        8'h01
`define DATA_RESET       19'h00000

`endif

// ==== gpio_pkg.sv ====
// Types shared by the GPIO block
package gpio_pkg;
   typedef logic [7:0] cfg_type;
   typedef enum {
      SEL_NONE,
      SEL_PLAIN,
      SEL_LED,
      SEL_EXP,
      SEL_CFG
   } reg_sel_type;
endpackage

// ==== gpio_pin_cell.sv ====
// One GPIO pin: direction, polarity, driver type and alternate function path
`include "gpio_map.svh"
module gpio_pin_cell import gpio_pkg::*; #(
   parameter bit EDGE_CAP   = 1'b0,
   parameter bit POL_EXEMPT = 1'b0
) (
   // Clock and reset
   input  wire logic i_mclk,
   input  wire logic i_rst_n,
   // Configuration and data
   input  wire cfg_type i_cfg,
   input  wire logic i_data,
   output logic      o_rd_bit,
   // Alternate function
   input  wire logic i_alt_out,
   input  wire logic i_alt_oe,
   output logic      o_alt_in,
   // Pin
   input  wire logic i_pin,
   output logic      o_pin_out,
   output logic      o_pin_oe
);
   logic pin_q;
   logic next_pin_out;
   logic next_pin_oe;
   logic next_alt_in;
   logic edge_mode;
   logic inv;
   logic alt_inv;
   logic val;
   logic drive;

   // ****************************************
   // Pin path
   // ****************************************
   always_comb begin
      edge_mode = EDGE_CAP & i_cfg[`CFG_EDGE_BIT];
      inv       = i_cfg[`CFG_POL_BIT];
      alt_inv   = inv & ~POL_EXEMPT & ~edge_mode;
      if (i_cfg[`CFG_ALT_BIT]) begin
         val   = i_alt_out ^ alt_inv;
         drive = i_alt_oe & ~edge_mode;
      end else begin
         val   = i_data ^ inv;
         drive = ~i_cfg[`CFG_DIR_BIT] & ~edge_mode;
      end
      // Open drain never drives high; the board pull-up does
      next_pin_out = val;
      next_pin_oe  = drive & (~i_cfg[`CFG_DRV_BIT] | ~val);
      next_alt_in  = pin_q ^ alt_inv;
      o_rd_bit     = (i_cfg[`CFG_DIR_BIT] | edge_mode) ? (pin_q ^ inv) : i_data;
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_q     <= 1'b0;
         o_pin_out <= 1'b0;
         o_pin_oe  <= 1'b0;
         o_alt_in  <= 1'b0;
      end else begin
         pin_q     <= i_pin;
         o_pin_out <= next_pin_out;
         o_pin_oe  <= next_pin_oe;
         o_alt_in  <= next_alt_in;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   a_out_drive_value: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (!i_cfg[`CFG_ALT_BIT] && !i_cfg[`CFG_DIR_BIT] && !i_cfg[`CFG_DRV_BIT] && !edge_mode)
      |=> (o_pin_oe && o_pin_out == $past(i_data ^ i_cfg[`CFG_POL_BIT])))
      else $error("output pin not driven with data");
   a_open_drain_low: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_cfg[`CFG_DRV_BIT] |=> !(o_pin_oe && o_pin_out))
      else $error("open drain pin driven high");
   a_input_read_pol: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (i_cfg[`CFG_DIR_BIT] && $stable(i_cfg)) |-> o_rd_bit == ($past(i_pin) ^ i_cfg[`CFG_POL_BIT]))
      else $error("input read value wrong");
   a_input_no_drive: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (!i_cfg[`CFG_ALT_BIT] && i_cfg[`CFG_DIR_BIT]) |=> !o_pin_oe)
      else $error("input pin is driven");
   a_alt_pol_in: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (i_cfg[`CFG_ALT_BIT] && !edge_mode && $stable(i_cfg))
      |-> ##1 o_alt_in == ($past(i_pin, 2) ^ ($past(i_cfg[`CFG_POL_BIT]) & !POL_EXEMPT)))
      else $error("alternate input polarity wrong");
   c_inverted_output: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
      o_pin_oe && !i_cfg[`CFG_DIR_BIT] && i_cfg[`CFG_POL_BIT]);
endmodule

// ==== gpio_port_tb_top.sv ====
// Self-checking APB bench for the GPIO port block
`include "gpio_map.svh"
module gpio_port_tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   // ****************************************
   // Signals and design instance
   // ****************************************
   localparam logic [11:0] A_PLAIN = {`IDX_PLAIN_DATA, 2'b00};
   localparam logic [11:0] A_LED   = {`IDX_LED_DATA, 2'b00};
   localparam logic [11:0] A_EXP   = {`IDX_EXP_DATA, 2'b00};
   localparam logic [11:0] A_CFG   = {`IDX_CFG_BASE, 2'b00};
   logic        i_mclk;
   logic        i_rst_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [18:0] alt_out;
   logic [18:0] alt_oe;
   logic [18:0] alt_in;
   logic [18:0] pin_in;
   logic [18:0] pin_out;
   logic [18:0] pin_oe;
   logic [18:0] v;
   logic [18:0] x;
   logic [31:0] rd;
   logic        err;
   int          fails;
   int          num_checks;
   int          cyc;

   gpio_port dut (
      .i_mclk    (i_mclk),
      .i_rst_n   (i_rst_n),
      .i_psel    (psel),
      .i_penable (penable),
      .i_pwrite  (pwrite),
      .i_paddr   (paddr),
      .i_pwdata  (pwdata),
      .o_prdata  (prdata),
      .o_pready  (pready),
      .o_pslverr (pslverr),
      .i_alt_out (alt_out),
      .i_alt_oe  (alt_oe),
      .o_alt_in  (alt_in),
      .i_pin     (pin_in),
      .o_pin_out (pin_out),
      .o_pin_oe  (pin_oe)
   );

   // ****************************************
   // Clock, watchdog and reporting
   // ****************************************
   initial begin
      i_mclk = 1'b0;
      forever #20 i_mclk = ~i_mclk;
   end

   // Generous ceiling: the whole sequence needs well under a thousand cycles
   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         close_out();
      end
   end

   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // ****************************************
   // APB master tasks
   // ****************************************
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge i_mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge i_mclk);
      penable <= 1'b1;
      // No latency assumed: a dead slave is caught by the watchdog
      do begin
         @(posedge i_mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   task automatic cfg_all(input logic [7:0] c);
      for (int p = 0; p < 19; p++) begin
         apb(1'b1, A_CFG + 12'(4 * p), {24'h0, c});
      end
   endtask

   // Unassigned led bank bits are written as ones so their read of zero means something
   task automatic set_data(input logic [18:0] d);
      apb(1'b1, A_PLAIN, {24'h0, d[7:0]});
      apb(1'b1, A_LED, {24'h0, 5'h1f, d[10:8]});
      apb(1'b1, A_EXP, {24'h0, d[18:11]});
   endtask

   task automatic rd_banks(input logic [18:0] d);
      rdchk(A_PLAIN, {24'h0, d[7:0]});
      rdchk(A_LED, {29'h0, d[10:8]});
      rdchk(A_EXP, {24'h0, d[18:11]});
   endtask

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      i_rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      alt_out = 19'h00000;
      alt_oe = 19'h00000;
      pin_in = 19'h00000;
      repeat (2) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      for (int p = 0; p < 19; p++) begin
         rdchk(A_CFG + 12'(4 * p), 32'(`CFG_RESET));
      end
      chk(32'(pin_oe), 32'h0);
      rd_banks(19'h00000);
      chk({31'h0, err}, 32'h0);
      apb(1'b0, 12'h200, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, A_PLAIN + 12'h001, 32'hff);
      chk({31'h0, err}, 32'h1);
      $display("test reset and decode done");
      cfg_all(8'h00);
      v = 19'h5b7a5;
      set_data(v);
      repeat (2) @(posedge i_mclk);
      chk(32'(pin_oe), 32'h7ffff);
      chk(32'(pin_out), 32'(v));
      rd_banks(v);
      x = ~v;
      cfg_all(8'h02);
      repeat (2) @(posedge i_mclk);
      chk(32'(pin_out), 32'(x));
      rd_banks(v);
      cfg_all(8'h80);
      repeat (2) @(posedge i_mclk);
      chk(32'(pin_oe), 32'(x));
      chk(32'(pin_out & pin_oe), 32'h0);
      $display("test output pins done");
      pin_in <= 19'h2c5a3;
      cfg_all(8'h01);
      set_data(19'h00000);
      chk(32'(pin_oe), 32'h0);
      rd_banks(19'h2c5a3);
      cfg_all(8'h03);
      repeat (3) @(posedge i_mclk);
      rd_banks(~19'h2c5a3);
      $display("test input pins done");
      alt_oe <= 19'h7ffff;
      alt_out <= 19'h3a6c9;
      cfg_all(8'h04);
      repeat (3) @(posedge i_mclk);
      chk(32'(pin_out), 32'(alt_out));
      chk(32'(alt_in), 32'(pin_in));
      cfg_all(8'h86);
      repeat (3) @(posedge i_mclk);
      x = alt_out ^ ~`POL_EXEMPT_MASK;
      v = ~x;
      chk(32'(pin_oe), 32'(v));
      chk(32'(pin_out & pin_oe), 32'h0);
      x = pin_in ^ ~`POL_EXEMPT_MASK;
      chk(32'(alt_in), 32'(x));
      // Only pins 8 and 9 can run in either-edge mode
      apb(1'b1, A_CFG + 12'h020, 32'h0a);
      apb(1'b1, A_CFG + 12'h024, 32'h0a);
      repeat (3) @(posedge i_mclk);
      chk(32'(alt_in[9:8]), 32'(pin_in[9:8]));
      chk(32'(pin_oe[9:8]), 32'h0);
      // Edge mode still inverts the data bit; pin 10 reads its stored output
      rdchk(A_LED, 32'h6);
      $display("test alternate functions done");
      close_out();
   end
endmodule
